// >>> inc/tefid_defs.vh
// Register offsets, field positions, reset values and codes for the timer event flag block
`ifndef TEFID_DEFS_VH
`define TEFID_DEFS_VH

// Register offsets (byte addresses)
`define TEFID_OFS_CTRL 8'h00
`define TEFID_OFS_ENABLE 8'h0C
`define TEFID_OFS_STATUS 8'h10
`define TEFID_OFS_EVGEN 8'h14

// Reset values
`define TEFID_RST_CTRL 16'h0000
`define TEFID_RST_ENABLE 16'h0000
`define TEFID_RST_STATUS 16'h0000

// Writable masks (reserved bits read zero, ignore writes)
`define TEFID_MASK_CTRL 16'h0373
`define TEFID_MASK_ENABLE 16'h47E7
`define TEFID_MASK_STATUS 16'h06E7
`define TEFID_MASK_EVGEN 16'h00E7

// Control register fields
`define TEFID_CTRL_UPD_DIS 0
`define TEFID_CTRL_UPD_SRC 1
`define TEFID_CTRL_TSEL_LO 4
`define TEFID_CTRL_TSEL_HI 6
`define TEFID_CTRL_CH1_IN 8

// Enable register fields
`define TEFID_EN_UPD_IRQ 0
`define TEFID_EN_CH1_IRQ 1
`define TEFID_EN_COM_IRQ 5
`define TEFID_EN_TRG_IRQ 6
`define TEFID_EN_BRK_IRQ 7
`define TEFID_EN_UPD_DMA 8
`define TEFID_EN_CH1_DMA 9
`define TEFID_EN_TRG_DMA 14

// Status register fields
`define TEFID_ST_UPD 0
`define TEFID_ST_CH1 1
`define TEFID_ST_COM 5
`define TEFID_ST_TRG 6
`define TEFID_ST_BRK 7
`define TEFID_ST_CH1_RPT 9

// Event generate fields
`define TEFID_EG_UPD 0
`define TEFID_EG_CH1 1
`define TEFID_EG_COM 5
`define TEFID_EG_TRG 6
`define TEFID_EG_BRK 7

// Trigger source codes
`define TEFID_TSEL_INTERNAL_TRIGGER_0 3'h0
`define TEFID_TSEL_INTERNAL_TRIGGER_1 3'h1
`define TEFID_TSEL_INTERNAL_TRIGGER_2 3'h2
`define TEFID_TSEL_INTERNAL_TRIGGER_3 3'h3

`endif

// >>> rtl/tefid_sync.v
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns

module tefid_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// Asynchronous input and synchronised output
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// ==========================================================
	// Two stage capture
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;

endmodule // tefid_sync

// >>> rtl/tefid_top.v
// Event flags, interrupt and DMA request enables and trigger source mapping of the timer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "tefid_defs.vh"

// Overview of operation
// - Trigger select codes 000..011 route partner timers a, b, c, d as trigger
// - Enable bits 0,1,2,5,6,7 enable update, channel, control-update, trigger, break irqs
// - Enable bits 8,9,10,14 enable update, channel 1, channel 2, trigger DMA
// - Enable and status registers reset to all zeros
// - Update flag bit 0 sets on every update event, held until cleared
// - Repetition counter overflow or underflow makes an update unless disabled
// - Software update generate makes an update when source bit zero, not disabled
// - Trigger counter initialisation makes an update when source bit zero, not disabled
// - Output channel 1 flag sets when counter matches compare value
// - Input channel 1 flag sets on capture, cleared by zero write or read
// - Channel 2 flag at bit 2 behaves exactly like channel 1
// - Control-update flag bit 5 sets on control-update event, held until cleared
// - Trigger flag bit 6 sets on trigger event, held until cleared
// - Break flag bit 7 set while break active; clearable only when inactive
// - Input capture while channel 1 flag set sets repeat flag bit 9
// - Channel 2 repeat flag bit 10 behaves as channel 1 repeat flag
// - Software update generate bit self-clears after requesting an update
module tefid_top (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// Register port
	input wire [7:0] i_reg_addr,
	input wire [15:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [15:0] o_reg_rdata,
	// Counter events
	input wire i_rep_wrap,
	input wire i_trig_init,
	// Channel events
	input wire [1:0] i_chan_match,
	input wire [1:0] i_chan_capture,
	input wire [1:0] i_chan_cap_read,
	// Control-update and trigger events
	input wire i_control_update_event,
	input wire i_trigger_event,
	// Break pin
	input wire i_break_pin,
	// Partner timer triggers
	input wire i_partner_timer_a,
	input wire i_partner_timer_b,
	input wire i_partner_timer_c,
	input wire i_partner_timer_d,
	// Event outputs
	output reg o_internal_trigger,
	output reg o_update_event,
	output reg [1:0] o_chan_soft_event,
	// Requests
	output wire o_irq,
	output reg o_dma_update,
	output reg [1:0] o_dma_chan,
	output reg o_dma_trigger
);

	// ==========================================================
	// Registers and signals
	reg [15:0] ctrl_reg;
	reg [15:0] enable_reg;
	reg [15:0] status_reg;
	reg [15:0] status_next;
	reg [15:0] evgen_reg;
	wire break_sync;
	wire update_disable;
	wire update_request_source;
	wire [2:0] trigger_source_select;
	wire [1:0] chan_input_mode;
	wire wr_ctrl;
	wire wr_enable;
	wire wr_status;
	wire wr_evgen;
	wire soft_update_generate;
	wire soft_com;
	wire soft_trig;
	wire soft_break;
	wire [1:0] soft_chan;
	wire update_ev;
	wire com_ev;
	wire trig_ev;
	wire [1:0] chan_ev;
	wire [1:0] chan_cap;
	wire [15:0] status_clr;
	wire [15:0] status_set;

	assign update_disable = ctrl_reg[`TEFID_CTRL_UPD_DIS];
	assign update_request_source = ctrl_reg[`TEFID_CTRL_UPD_SRC];
	assign trigger_source_select = ctrl_reg[`TEFID_CTRL_TSEL_HI:`TEFID_CTRL_TSEL_LO];
	assign chan_input_mode = ctrl_reg[`TEFID_CTRL_CH1_IN+1:`TEFID_CTRL_CH1_IN];

	assign wr_ctrl = i_reg_wr && (i_reg_addr == `TEFID_OFS_CTRL);
	assign wr_enable = i_reg_wr && (i_reg_addr == `TEFID_OFS_ENABLE);
	assign wr_status = i_reg_wr && (i_reg_addr == `TEFID_OFS_STATUS);
	assign wr_evgen = i_reg_wr && (i_reg_addr == `TEFID_OFS_EVGEN);

	assign soft_update_generate = evgen_reg[`TEFID_EG_UPD];
	assign soft_chan = evgen_reg[`TEFID_EG_CH1+1:`TEFID_EG_CH1];
	assign soft_com = evgen_reg[`TEFID_EG_COM];
	assign soft_trig = evgen_reg[`TEFID_EG_TRG];
	assign soft_break = evgen_reg[`TEFID_EG_BRK];

	// ==========================================================
	// Break pin synchroniser
	tefid_sync #(
		.WIDTH(1)
	) u_break_sync (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_async(i_break_pin),
		.o_sync(break_sync)
	);

	// ==========================================================
	// Configuration registers
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			ctrl_reg <= `TEFID_RST_CTRL;
			enable_reg <= `TEFID_RST_ENABLE;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= i_reg_wdata & `TEFID_MASK_CTRL;
			end
			if (wr_enable) begin
				enable_reg <= i_reg_wdata & `TEFID_MASK_ENABLE;
			end
		end
	end

	// ==========================================================
	// Event generate register
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			evgen_reg <= 16'h0000;
		end else if (wr_evgen) begin
			evgen_reg <= i_reg_wdata & `TEFID_MASK_EVGEN;
		end else begin
			evgen_reg <= 16'h0000;
		end
	end

	// ==========================================================
	// Trigger source mapping
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_internal_trigger <= 1'b0;
		end else begin
			case (trigger_source_select)
				`TEFID_TSEL_INTERNAL_TRIGGER_0: begin
					o_internal_trigger <= i_partner_timer_a;
				end
				`TEFID_TSEL_INTERNAL_TRIGGER_1: begin
					o_internal_trigger <= i_partner_timer_b;
				end
				`TEFID_TSEL_INTERNAL_TRIGGER_2: begin
					o_internal_trigger <= i_partner_timer_c;
				end
				`TEFID_TSEL_INTERNAL_TRIGGER_3: begin
					o_internal_trigger <= i_partner_timer_d;
				end
				default: begin
					o_internal_trigger <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Event qualification
	// Update from repetition wrap, software update generate or trigger initialisation
	assign update_ev = !update_disable && (i_rep_wrap ||
		(!update_request_source && (soft_update_generate || i_trig_init)));
	assign com_ev = i_control_update_event || soft_com;
	assign trig_ev = i_trigger_event || soft_trig;

	// Zero bits of a status write clear, one bits keep
	// Write zero clears
	assign status_clr = wr_status ? (~i_reg_wdata & `TEFID_MASK_STATUS) : 16'h0000;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			assign chan_cap[ch] = chan_input_mode[ch] && (i_chan_capture[ch] || soft_chan[ch]);
			assign chan_ev[ch] = chan_cap[ch] ||
				(!chan_input_mode[ch] && (i_chan_match[ch] || soft_chan[ch]));
			assign status_set[`TEFID_ST_CH1+ch] = chan_ev[ch];
			assign status_set[`TEFID_ST_CH1_RPT+ch] = chan_cap[ch] &&
				status_reg[`TEFID_ST_CH1+ch];
		end
	endgenerate

	assign status_set[`TEFID_ST_UPD] = update_ev;
	assign status_set[4:3] = 2'b00;
	assign status_set[`TEFID_ST_COM] = com_ev;
	assign status_set[`TEFID_ST_TRG] = trig_ev;
	assign status_set[`TEFID_ST_BRK] = break_sync || soft_break;
	assign status_set[8] = 1'b0;
	assign status_set[15:11] = 5'b0_0000;

	// ==========================================================
	// Status next value
	always @* begin
		status_next = status_reg & ~status_clr;
		if (chan_input_mode[0] && i_chan_cap_read[0]) begin
			status_next[`TEFID_ST_CH1] = 1'b0;
		end
		if (chan_input_mode[1] && i_chan_cap_read[1]) begin
			status_next[`TEFID_ST_CH1+1] = 1'b0;
		end
		// Set wins over clear
		status_next = (status_next | status_set) & `TEFID_MASK_STATUS;
	end

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			status_reg <= `TEFID_RST_STATUS;
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// Requests and event outputs
	// Enabled flag irq
	assign o_irq = |(status_reg[7:0] & enable_reg[7:0] & 8'hE7) ||
		(|(status_reg[10:9] & enable_reg[2:1]));

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_dma_update <= 1'b0;
			o_dma_chan <= 2'b00;
			o_dma_trigger <= 1'b0;
			o_update_event <= 1'b0;
			o_chan_soft_event <= 2'b00;
		end else begin
			o_dma_update <= update_ev && enable_reg[`TEFID_EN_UPD_DMA];
			o_dma_chan <= chan_ev & enable_reg[`TEFID_EN_CH1_DMA+1:`TEFID_EN_CH1_DMA];
			o_dma_trigger <= trig_ev && enable_reg[`TEFID_EN_TRG_DMA];
			o_update_event <= update_ev;
			o_chan_soft_event <= soft_chan;
		end
	end

	// ==========================================================
	// Register read port
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`TEFID_OFS_CTRL: begin
					o_reg_rdata <= ctrl_reg;
				end
				`TEFID_OFS_ENABLE: begin
					o_reg_rdata <= enable_reg;
				end
				`TEFID_OFS_STATUS: begin
					o_reg_rdata <= status_reg;
				end
				`TEFID_OFS_EVGEN: begin
					o_reg_rdata <= evgen_reg;
				end
				default: begin
					o_reg_rdata <= 16'h0000;
				end
			endcase
		end else begin
			o_reg_rdata <= 16'h0000;
		end
	end

endmodule // tefid_top

// >>> tb/tefid_top_asserts.sv
// Assertion checker for the timer event flag block
`timescale 1ns/1ns
module tefid_chk (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	// Events
	input wire logic i_rep_wrap,
	input wire logic i_trig_init,
	input wire logic i_trigger_event,
	input wire logic i_control_update_event,
	input wire logic [1:0] i_chan_match,
	input wire logic [1:0] i_chan_capture,
	input wire logic i_break_pin,
	input wire logic i_partner_timer_a,
	input wire logic i_partner_timer_b,
	input wire logic i_partner_timer_c,
	input wire logic i_partner_timer_d,
	// Outputs
	input wire logic o_internal_trigger,
	input wire logic o_update_event,
	input wire logic o_irq,
	input wire logic o_dma_update,
	input wire logic [1:0] o_dma_chan,
	input wire logic [1:0] o_chan_soft_event,
	input wire logic o_dma_trigger
);
	// ==========
	// Shadow registers
	logic [15:0] en_reg;
	logic [15:0] ctrl_reg;
	logic [3:0] pt;
	logic exp_trig;
	assign pt = {i_partner_timer_d, i_partner_timer_c, i_partner_timer_b, i_partner_timer_a};
	assign exp_trig = ctrl_reg[6] ? 1'b0 : pt[ctrl_reg[5:4]];
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			en_reg <= 16'h0000;
			ctrl_reg <= 16'h0000;
		end else if (i_reg_wr && i_reg_addr == 8'h0C) begin
			en_reg <= i_reg_wdata & 16'h47E7;
		end else if (i_reg_wr && i_reg_addr == 8'h00) begin
			ctrl_reg <= i_reg_wdata & 16'h0373;
		end
	end
	// ==========
	// Assertions
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	AST_TRIG_MAP: assert property (
		!$past(i_srst) |-> o_internal_trigger == $past(exp_trig))
		else $error("internal trigger wrong");
	AST_EN_RD: assert property (
		i_reg_rd && i_reg_addr == 8'h0C |=> o_reg_rdata == $past(en_reg))
		else $error("enable readback wrong");
	AST_RD_IDLE: assert property (
		!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	AST_UPD_EVT: assert property (
		i_rep_wrap && !ctrl_reg[0] |=> o_update_event)
		else $error("no update on wrap");
	AST_SOFT_UPD: assert property (
		i_reg_wr && i_reg_addr == 8'h14 && i_reg_wdata[0]
		&& ctrl_reg[1:0] == 2'b00 |=> ##1 o_update_event)
		else $error("no update on soft generate");
	AST_TRIG_INIT: assert property (
		i_trig_init && ctrl_reg[1:0] == 2'b00 |=> o_update_event)
		else $error("no update on trigger init");
	AST_UPD_DMA: assert property (
		i_rep_wrap && !ctrl_reg[0] && en_reg[8] |=> o_dma_update)
		else $error("no update dma");
	AST_DMA_TRG: assert property (
		i_trigger_event && en_reg[14] |=> o_dma_trigger)
		else $error("no trigger dma");
	AST_DMA_GATE: assert property (
		o_dma_trigger |-> $past(en_reg[14]))
		else $error("trigger dma while disabled");
	AST_UPD_IRQ: assert property (
		i_rep_wrap && !ctrl_reg[0] && en_reg[0] && !i_reg_wr |=> o_irq)
		else $error("no update irq");
	AST_BRK_IRQ: assert property (
		i_break_pin [*3] ##0 (en_reg[7] && !i_reg_wr) |=> o_irq)
		else $error("no break irq");
	AST_IRQ_OFF: assert property (
		en_reg[7:0] == 8'h00 |-> !o_irq)
		else $error("irq while all masked");
	AST_CH1_DMA: assert property (
		i_chan_match[0] && !ctrl_reg[8] && en_reg[9] |=> o_dma_chan[0])
		else $error("no channel 1 dma on match");
	AST_CH2_DMA: assert property (
		i_chan_capture[1] && ctrl_reg[9] && en_reg[10] |=> o_dma_chan[1])
		else $error("no channel 2 dma on capture");
	AST_COM_IRQ: assert property (
		i_control_update_event && en_reg[5] && !i_reg_wr |=> o_irq)
		else $error("no control update irq");
	AST_SOFT_CH: assert property (
		i_reg_wr && i_reg_addr == 8'h14 && i_reg_wdata[1] |=> ##1 o_chan_soft_event[0])
		else $error("no soft channel event");
	// ==========
	// Covers
	cover property (i_break_pin [*3]);
	cover property (i_trigger_event && en_reg[14]);
	cover property (i_rep_wrap && en_reg[0]);
	cover property (o_chan_soft_event != 2'b00);
	cover property (o_dma_chan != 2'b00);
endmodule // tefid_chk

bind tefid_top tefid_chk chk_u (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_rep_wrap(i_rep_wrap), .i_trig_init(i_trig_init),
	.i_trigger_event(i_trigger_event), .i_break_pin(i_break_pin),
	.i_control_update_event(i_control_update_event), .i_chan_match(i_chan_match),
	.i_chan_capture(i_chan_capture), .o_dma_chan(o_dma_chan),
	.o_chan_soft_event(o_chan_soft_event),
	.i_partner_timer_a(i_partner_timer_a), .i_partner_timer_b(i_partner_timer_b),
	.i_partner_timer_c(i_partner_timer_c), .i_partner_timer_d(i_partner_timer_d),
	.o_internal_trigger(o_internal_trigger), .o_update_event(o_update_event),
	.o_irq(o_irq), .o_dma_update(o_dma_update), .o_dma_trigger(o_dma_trigger)
);

// >>> tb/tefid_top_tb_top.sv
// Self-checking testbench for the timer event flag block
`timescale 1ns/1ns
module tefid_top_tb_top;
	// ==========
	// Signals
	logic i_clk_sys = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] i_reg_addr = 8'h00;
	logic [15:0] i_reg_wdata = 16'h0000;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [9:0] ev = 10'h000;
	logic i_break_pin = 1'b0;
	logic [3:0] pt = 4'h0;
	logic [15:0] o_reg_rdata;
	logic o_irq;
	logic rd_d = 1'b0;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'hd9f1_b4e5;
	int n_mismatch = 0;
	int checks = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	tefid_top dut_u (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_rep_wrap(ev[0]), .i_trig_init(ev[1]),
		.i_chan_match(ev[3:2]), .i_chan_capture(ev[5:4]), .i_chan_cap_read(ev[7:6]),
		.i_control_update_event(ev[8]), .i_trigger_event(ev[9]), .i_break_pin(i_break_pin),
		.i_partner_timer_a(pt[0]), .i_partner_timer_b(pt[1]), .i_partner_timer_c(pt[2]),
		.i_partner_timer_d(pt[3]), .o_internal_trigger(), .o_update_event(),
		.o_chan_soft_event(), .o_irq(o_irq), .o_dma_update(), .o_dma_chan(), .o_dma_trigger()
	);
	// ==========
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Write when w is set, else read and note d as expected
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		i_reg_wr <= w;
		i_reg_rd <= !w;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		ev <= 10'h000;
		if (!w) exp_q.push_back(d);
		@(posedge i_clk_sys);
	endtask
	task automatic pulse(input logic [9:0] m, input int n);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		ev <= m;
		@(posedge i_clk_sys);
		ev <= 10'h000;
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic st(input logic [15:0] e);
		bus(0, 8'h10, e);
		bus(1, 8'h10, 16'h0000);
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========
	// Output monitor and random partner triggers
	always @(posedge i_clk_sys) begin
		if (rd_d) chk("rdata", o_reg_rdata, exp_q.pop_front());
		rd_d <= i_reg_rd;
		pt <= 4'(rnd());
	end
	initial begin
		repeat (3000) @(posedge i_clk_sys);
		n_mismatch++;
		end_sim();
	end
	// ==========
	// Scenarios
	initial begin
		logic [15:0] r;
		repeat (3) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		bus(0, 8'h0C, 16'h0000);
		bus(0, 8'h10, 16'h0000);
		bus(0, 8'h20, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			r = 16'(rnd());
			bus(1, 8'h0C, r);
			bus(0, 8'h0C, r & 16'h47E7);
		end
		bus(1, 8'h0C, 16'h0000);
		pulse(10'h001, 1);
		chk("irq", {15'h0000, o_irq}, 16'h0000);
		bus(1, 8'h0C, 16'h47E7);
		pulse(10'h001, 1);
		chk("irq", {15'h0000, o_irq}, 16'h0001);
		bus(1, 8'h10, 16'hFFFF);
		st(16'h0001);
		bus(1, 8'h00, 16'h0001);
		pulse(10'h001, 1);
		st(16'h0000);
		bus(1, 8'h00, 16'h0002);
		bus(1, 8'h14, 16'h0001);
		pulse(10'h002, 2);
		st(16'h0000);
		bus(1, 8'h00, 16'h0000);
		bus(1, 8'h14, 16'h0001);
		pulse(10'h000, 2);
		bus(0, 8'h14, 16'h0000);
		st(16'h0001);
		pulse(10'h002, 1);
		st(16'h0001);
		pulse(10'h03C, 1);
		st(16'h0006);
		bus(1, 8'h00, 16'h0300);
		pulse(10'h03C, 1);
		pulse(10'h030, 1);
		pulse(10'h040, 1);
		st(16'h0604);
		bus(1, 8'h00, 16'h0000);
		pulse(10'h300, 1);
		st(16'h0060);
		i_break_pin <= 1'b1;
		pulse(10'h000, 4);
		st(16'h0080);
		bus(0, 8'h10, 16'h0080);
		i_break_pin <= 1'b0;
		pulse(10'h000, 4);
		st(16'h0080);
		bus(1, 8'h14, 16'h00E6);
		pulse(10'h000, 1);
		st(16'h00E6);
		pulse(10'h000, 1);
		chk("irq", {15'h0000, o_irq}, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			bus(1, 8'h00, 16'(k) << 4);
			pulse(10'h000, 3);
		end
		pulse(10'h000, 3);
		end_sim();
	end
endmodule // tefid_top_tb_top
